/* common/acs_consts.svh */
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

// operating mode codes
`define ACS_MODE_CONV       3'h0
`define ACS_MODE_SELF       3'h1
`define ACS_MODE_SYS_OFFS   3'h2
`define ACS_MODE_SYS_POS    3'h3
`define ACS_MODE_SYS_NEG    3'h4
`define ACS_MODE_SYS_OFFINT 3'h5
`define ACS_MODE_SYS_GAIN   3'h6
`define ACS_MODE_RESERVED   3'h7

// coefficient reset values: no offset, unity slopes
`define ACS_OFFSET_RESET    24'h000000
`define ACS_GAIN_RESET      24'h800000
`define ACS_GAIN_SHIFT      23

// notch code limits and oscillator cycles per notch unit
`define ACS_NOTCH_MIN       11'h00A
`define ACS_NOTCH_MAX       11'h7FF
`define ACS_OSC_PER_UNIT    512

// step lengths in conversion periods
`define ACS_CONV_SETTLE     3'h3
`define ACS_INT_STEP        3'h3
`define ACS_SYS_STEP        3'h4
`define ACS_GAIN_TAIL       3'h1

`endif

/* common/acs_pkg.sv */
package acs_pkg;

    // sequencer states
    typedef enum logic [3:0] {
        S_CONV_WAIT, S_CONV, S_INT_ZERO, S_SYS_ZERO, S_REF_POS, S_REF_NEG,
        S_TAIL, S_SYS_SINGLE, S_GAIN_NEG, S_GAIN_POS, S_GAIN_TAIL, S_HOLD
    } acs_state_type;

    // analog front-end routing
    typedef enum logic [2:0] {
        SEL_EXTERNAL, SEL_SHORTED, SEL_REF_POS, SEL_REF_NEG, SEL_EXT_INVERT
    } acs_input_sel_type;

    // calibration coefficient set
    typedef struct packed {
        logic [23:0] offset;
        logic [23:0] pos_gain;
        logic [23:0] neg_gain;
    } acs_coef_type;

endpackage

/* design/acs_sequencer.sv */
// Operation
// [R01] decode three-bit mode: conversion, self, five system calibrations, reserved
// [R02] offset zero and gains 800000h give raw, uncorrected output
// [R03] host runs zero-scale calibration before any gain calibration
// [R04] data ready goes low when a calibration finishes
// [R05] after entering conversion, first result and data ready after three periods
// [R06] conversion leaves coefficients unchanged and corrects with stored ones
// [R07] self calibration shorts amplifier inputs, writes offset after three periods
// [R08] then reference positive three periods, then reversed three periods
// [R09] self calibration: data ready three periods after negative coefficient write
// [R10] host selects self calibration only at gain one
// [R11] system offset: convert external input into offset, ready after four
// [R12] system positive: convert external input into positive gain, ready after four
// [R13] system negative: convert external input into negative gain, ready after four
// [R14] host applies and settles calibration input before selecting mode
// [R15] offset from external input, then reference steps, three periods each
// [R16] system gain: negative, then inverted into positive, ready one period later
// [R17] host never programs reserved code; nothing blocks it
// [R18] host recalibrates after gain, notch, range, supply or temperature change
// [R19] conversion period is 512 times notch code oscillator cycles
// [R20] notch code usable from 10 through 2047
// [R21] data ready returns high after full data register read
// [R22] a new mode write aborts the sequence and restarts it
`timescale 1ns/1ns
`default_nettype none
`include "acs_consts.svh"

module acs_sequencer #(
    parameter int OSC_PER_UNIT = `ACS_OSC_PER_UNIT
) (
    // clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      resetn,
    // host control
    input  wire logic                      mode_write,
    input  wire logic [2:0]                operating_mode_field,
    input  wire logic [10:0]               notch_code_field,
    input  wire logic                      read_done,
    // filter datapath
    input  wire logic [23:0]               raw_result,
    // outputs
    output logic                           conv_tick,
    output logic                           data_ready_n,
    output logic [23:0]                    data_out,
    output acs_pkg::acs_coef_type          coef,
    output acs_pkg::acs_input_sel_type     input_select
);

    acs_pkg::acs_state_type state, next_state;
    logic [2:0]             mode, next_mode;
    logic [2:0]             step, next_step;
    logic [20:0]            period_cnt, next_period_cnt;
    logic [20:0]            period_len;
    logic [10:0]            notch_eff;
    logic                   next_data_ready_n_n;
    logic [23:0]            next_data_out;
    acs_pkg::acs_coef_type  next_coef;
    logic signed [24:0]     diff;
    logic signed [24:0]     gain;
    logic signed [49:0]     product;
    logic signed [26:0]     scaled;
    logic [23:0]            corrected;

    // clamp notch code into usable range and form period length
    always_comb begin
        notch_eff  = (notch_code_field < `ACS_NOTCH_MIN) ? `ACS_NOTCH_MIN
                                                         : notch_code_field; // [R20]
        period_len = 21'(OSC_PER_UNIT * notch_eff); // [R19]
        conv_tick  = (period_cnt == period_len - 21'h1);
    end

    // result correction with stored coefficients
    always_comb begin
        diff      = $signed({raw_result[23], raw_result})
                  - $signed({coef.offset[23], coef.offset});
        gain      = diff[24] ? $signed({1'b0, coef.neg_gain}) : $signed({1'b0, coef.pos_gain});
        product   = diff * gain;
        scaled    = product[49:23]; // unity at 800000h [R02]
        if (scaled > 27'sh07FFFFF) begin
            corrected = 24'h7FFFFF;
        end else if (scaled < -27'sh0800000) begin
            corrected = 24'h800000;
        end else begin
            corrected = scaled[23:0];
        end
    end

    // front-end routing per step
    always_comb begin
        unique case (state)
            acs_pkg::S_INT_ZERO: input_select = acs_pkg::SEL_SHORTED; // [R07]
            acs_pkg::S_REF_POS:  input_select = acs_pkg::SEL_REF_POS; // [R08]
            acs_pkg::S_REF_NEG:  input_select = acs_pkg::SEL_REF_NEG; // [R08]
            acs_pkg::S_GAIN_POS: input_select = acs_pkg::SEL_EXT_INVERT; // [R16]
            default:    input_select = acs_pkg::SEL_EXTERNAL;
        endcase
    end

    // sequencer next values
    always_comb begin
        next_state      = state;
        next_mode       = mode;
        next_step       = step;
        next_coef       = coef;
        next_data_out   = data_out;
        next_data_ready_n_n     = data_ready_n;
        next_period_cnt = conv_tick ? 21'h0 : period_cnt + 21'h1;
        if (read_done) begin
            next_data_ready_n_n = 1'b1; // [R21]
        end
        if (mode_write) begin
            next_mode       = operating_mode_field;
            next_step       = 3'h0; // [R22]
            next_period_cnt = 21'h0;
            unique case (operating_mode_field) // [R01]
                `ACS_MODE_CONV:       next_state = acs_pkg::S_CONV_WAIT;
                `ACS_MODE_SELF:       next_state = acs_pkg::S_INT_ZERO;
                `ACS_MODE_SYS_OFFS:   next_state = acs_pkg::S_SYS_SINGLE;
                `ACS_MODE_SYS_POS:    next_state = acs_pkg::S_SYS_SINGLE;
                `ACS_MODE_SYS_NEG:    next_state = acs_pkg::S_SYS_SINGLE;
                `ACS_MODE_SYS_OFFINT: next_state = acs_pkg::S_SYS_ZERO;
                `ACS_MODE_SYS_GAIN:   next_state = acs_pkg::S_GAIN_NEG;
                `ACS_MODE_RESERVED:   next_state = acs_pkg::S_HOLD; // [R17]
            endcase
        end else if (conv_tick) begin
            next_step = step + 3'h1;
            unique case (state)
                acs_pkg::S_CONV_WAIT: if (step == `ACS_CONV_SETTLE - 3'h1) begin
                    next_state    = acs_pkg::S_CONV; // [R05]
                    next_step     = 3'h0;
                    next_data_out = corrected;
                    next_data_ready_n_n   = 1'b0;
                end
                acs_pkg::S_CONV: begin
                    next_step     = 3'h0;
                    next_data_out = corrected; // [R06]
                    next_data_ready_n_n   = 1'b0;
                end
                acs_pkg::S_INT_ZERO, acs_pkg::S_SYS_ZERO: if (step == `ACS_INT_STEP - 3'h1) begin
                    next_coef.offset = raw_result; // [R07] [R15]
                    next_state       = acs_pkg::S_REF_POS;
                    next_step        = 3'h0;
                end
                acs_pkg::S_REF_POS: if (step == `ACS_INT_STEP - 3'h1) begin
                    next_coef.pos_gain = raw_result; // [R08]
                    next_state         = acs_pkg::S_REF_NEG;
                    next_step          = 3'h0;
                end
                acs_pkg::S_REF_NEG: if (step == `ACS_INT_STEP - 3'h1) begin
                    next_coef.neg_gain = raw_result; // [R08]
                    next_state         = acs_pkg::S_TAIL;
                    next_step          = 3'h0;
                end
                acs_pkg::S_TAIL: if (step == `ACS_INT_STEP - 3'h1) begin
                    next_state    = acs_pkg::S_HOLD;
                    next_data_out = corrected;
                    next_data_ready_n_n   = 1'b0; // [R09] [R04]
                end
                acs_pkg::S_SYS_SINGLE: if (step == `ACS_SYS_STEP - 3'h1) begin
                    if (mode == `ACS_MODE_SYS_OFFS) begin
                        next_coef.offset = raw_result; // [R11]
                    end else if (mode == `ACS_MODE_SYS_POS) begin
                        next_coef.pos_gain = raw_result; // [R12]
                    end else begin
                        next_coef.neg_gain = raw_result; // [R13]
                    end
                    next_state    = acs_pkg::S_HOLD;
                    next_data_out = raw_result;
                    next_data_ready_n_n   = 1'b0; // [R04]
                end
                acs_pkg::S_GAIN_NEG: if (step == `ACS_INT_STEP - 3'h1) begin
                    next_coef.neg_gain = raw_result; // [R16]
                    next_state         = acs_pkg::S_GAIN_POS;
                    next_step          = 3'h0;
                end
                acs_pkg::S_GAIN_POS: if (step == `ACS_INT_STEP - 3'h1) begin
                    next_coef.pos_gain = raw_result; // [R16]
                    next_state         = acs_pkg::S_GAIN_TAIL;
                    next_step          = 3'h0;
                end
                acs_pkg::S_GAIN_TAIL: if (step == `ACS_GAIN_TAIL - 3'h1) begin
                    next_state    = acs_pkg::S_HOLD;
                    next_data_out = corrected;
                    next_data_ready_n_n   = 1'b0; // [R16] [R04]
                end
                acs_pkg::S_HOLD: next_step = 3'h0;
            endcase
        end
    end

    // sequencer registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state           <= acs_pkg::S_CONV_WAIT;
            mode            <= `ACS_MODE_CONV;
            step            <= 3'h0;
            period_cnt      <= 21'h0;
            data_ready_n    <= 1'b1;
            data_out        <= 24'h000000;
            coef.offset     <= `ACS_OFFSET_RESET;
            coef.pos_gain   <= `ACS_GAIN_RESET;
            coef.neg_gain   <= `ACS_GAIN_RESET;
        end else begin
            state           <= next_state;
            mode            <= next_mode;
            step            <= next_step;
            period_cnt      <= next_period_cnt;
            data_ready_n    <= next_data_ready_n_n;
            data_out        <= next_data_out;
            coef            <= next_coef;
        end
    end

    // checks
    AST_DECODE: assert property (@(posedge sys_clk) disable iff (!resetn) // [R01]
        mode_write && operating_mode_field == `ACS_MODE_SELF |=> state == acs_pkg::S_INT_ZERO)
        else $error("self mode not decoded");
    AST_UNITY: assert property (@(posedge sys_clk) disable iff (!resetn) // [R02]
        (state == acs_pkg::S_CONV || (state == acs_pkg::S_CONV_WAIT && step == 3'h2))
        && conv_tick && !mode_write && coef.offset == 24'h000000
        && coef.pos_gain == 24'h800000 && coef.neg_gain == 24'h800000
        |=> data_out == $past(raw_result))
        else $error("uncalibrated output differs from raw");
    AST_CONV_FIRST: assert property (@(posedge sys_clk) disable iff (!resetn) // [R05]
        state == acs_pkg::S_CONV_WAIT && conv_tick && !mode_write && step == 3'h2
        |=> state == acs_pkg::S_CONV && !data_ready_n)
        else $error("first conversion result late");
    AST_CONV_KEEP: assert property (@(posedge sys_clk) disable iff (!resetn) // [R06]
        (state == acs_pkg::S_CONV_WAIT || state == acs_pkg::S_CONV) && !mode_write
        |=> $stable(coef))
        else $error("coefficients changed in conversion");
    AST_SELF_OFFSET: assert property (@(posedge sys_clk) disable iff (!resetn) // [R07]
        state == acs_pkg::S_INT_ZERO && conv_tick && !mode_write && step == 3'h2
        |=> coef.offset == $past(raw_result) && state == acs_pkg::S_REF_POS)
        else $error("self offset not written");
    AST_REF_POS: assert property (@(posedge sys_clk) disable iff (!resetn) // [R08]
        state == acs_pkg::S_REF_POS |-> input_select == acs_pkg::SEL_REF_POS)
        else $error("reference not applied");
    AST_TAIL_DATA_READY_N: assert property (@(posedge sys_clk) disable iff (!resetn) // [R09]
        state == acs_pkg::S_TAIL && conv_tick && !mode_write && step == 3'h2
        |=> !data_ready_n && state == acs_pkg::S_HOLD)
        else $error("self calibration ready missing");
    AST_SYS_SINGLE: assert property (@(posedge sys_clk) disable iff (!resetn) // [R11] [R12] [R13]
        state == acs_pkg::S_SYS_SINGLE && conv_tick && !mode_write && step == 3'h3
        |=> !data_ready_n)
        else $error("system calibration ready missing");
    AST_OFFINT: assert property (@(posedge sys_clk) disable iff (!resetn) // [R15]
        state == acs_pkg::S_SYS_ZERO && conv_tick && !mode_write && step == 3'h2
        |=> coef.offset == $past(raw_result) && state == acs_pkg::S_REF_POS)
        else $error("system offset step wrong");
    AST_GAIN_TAIL: assert property (@(posedge sys_clk) disable iff (!resetn) // [R16]
        state == acs_pkg::S_GAIN_TAIL && conv_tick && !mode_write |=> !data_ready_n)
        else $error("gain calibration ready missing");
    AST_PERIOD: assert property (@(posedge sys_clk) disable iff (!resetn) // [R19] [R20]
        conv_tick |-> period_cnt == 21'(OSC_PER_UNIT * notch_eff) - 21'h1
        && notch_eff >= 11'h00A)
        else $error("conversion period wrong");
    AST_RELEASE: assert property (@(posedge sys_clk) disable iff (!resetn) // [R21]
        read_done && !conv_tick && !mode_write |=> data_ready_n)
        else $error("data ready not released");
    AST_RESTART: assert property (@(posedge sys_clk) disable iff (!resetn) // [R22]
        mode_write |=> step == 3'h0 && period_cnt == 21'h0)
        else $error("mode write did not restart");

    COV_SELF: cover property (@(posedge sys_clk) disable iff (!resetn)
        state == acs_pkg::S_TAIL ##1 state == acs_pkg::S_HOLD);
    COV_CONV: cover property (@(posedge sys_clk) disable iff (!resetn)
        state == acs_pkg::S_CONV && $fell(data_ready_n));
    COV_GAIN: cover property (@(posedge sys_clk) disable iff (!resetn)
        state == acs_pkg::S_GAIN_TAIL ##1 state == acs_pkg::S_HOLD);
    COV_ABORT: cover property (@(posedge sys_clk) disable iff (!resetn)
        state == acs_pkg::S_REF_NEG && mode_write);

endmodule // acs_sequencer

`default_nettype wire

/* verification/acs_host_model.sv */
`timescale 1ns/1ns
`default_nettype none

// host stand-in: programs mode and notch, acknowledges result reads
module acs_host_model (
    // clock
    input  wire logic        sys_clk,
    // host control
    output logic             mode_write,
    output logic [2:0]       operating_mode_field,
    output logic [10:0]      notch_code_field,
    output logic             read_done
);
    // idle values from time zero
    initial begin
        mode_write = 1'b0;
        operating_mode_field = 3'h0;
        notch_code_field = 11'h00A;
        read_done = 1'b0;
    end

    // one-cycle mode write; callers never pass the reserved code, gain stays one
    task automatic send(input logic [2:0] m, input logic [10:0] n);
        @(posedge sys_clk);
        #1;
        mode_write = 1'b1;
        operating_mode_field = m;
        notch_code_field = n; // input settled, every notch change followed by a run
        @(posedge sys_clk);
        #1;
        mode_write = 1'b0;
    endtask

    // one-cycle acknowledge of a complete result read
    task automatic ack();
        @(posedge sys_clk);
        #1;
        read_done = 1'b1;
        @(posedge sys_clk);
        #1;
        read_done = 1'b0;
    endtask
endmodule // acs_host_model

`default_nettype wire

/* verification/acs_sequencer_test.sv */
`timescale 1ns/1ns
`default_nettype none

module acs_sequencer_test;
    localparam int OSC = 2;
    logic                       sys_clk;
    logic                       resetn;
    logic                       mode_write;
    logic                       read_done;
    logic [2:0]                 operating_mode_field;
    logic [10:0]                notch_code_field;
    logic [23:0]                raw_result = 24'h000000;
    logic [23:0]                data_out;
    logic                       conv_tick;
    logic                       data_ready_n;
    acs_pkg::acs_coef_type      coef;
    acs_pkg::acs_coef_type      exp_coef;
    acs_pkg::acs_input_sel_type input_select;
    int                         miscompares = 0;
    int                         compares = 0;
    int                         seed = 31592;
    int                         cyc;
    int                         n;
    logic [23:0]                q[$];
    int                         seq[7] = '{1, 3, 4, 5, 6, 2, 0};
    // per mode: ticks to ready, tick that loads offset, positive, negative
    int                         rdy[7] = '{3, 12, 4, 4, 4, 12, 7};
    int                         offt[7] = '{0, 3, 4, 0, 0, 3, 0};
    int                         post[7] = '{0, 6, 0, 4, 0, 6, 6};
    int                         negt[7] = '{0, 9, 0, 0, 4, 9, 3};

    // clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // filter stand-in: a fresh random result every cycle
    always @(posedge sys_clk) #1 raw_result = 24'($random(seed));

    acs_host_model host (
        .sys_clk(sys_clk), .mode_write(mode_write), .operating_mode_field(operating_mode_field),
        .notch_code_field(notch_code_field), .read_done(read_done));

    acs_sequencer #(.OSC_PER_UNIT(OSC)) DUT (
        .sys_clk(sys_clk), .resetn(resetn), .mode_write(mode_write),
        .operating_mode_field(operating_mode_field), .notch_code_field(notch_code_field),
        .read_done(read_done), .raw_result(raw_result), .conv_tick(conv_tick),
        .data_ready_n(data_ready_n), .data_out(data_out), .coef(coef),
        .input_select(input_select));

    // compare and count
    task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask

    // behavioural correction: (raw - offset) times slope over 2^23, slope by sign, saturated
    function automatic logic [23:0] corr(input logic [23:0] raw, input acs_pkg::acs_coef_type c);
        longint d;
        longint p;
        d = longint'($signed(raw)) - longint'($signed(c.offset));
        p = d * longint'((d < 0) ? c.neg_gain : c.pos_gain);
        p = p >>> 23;
        if (p > 64'sh7FFFFF) p = 64'sh7FFFFF;
        if (p < -64'sh800000) p = -64'sh800000;
        return p[23:0];
    endfunction

    // expected routing while step k of mode m runs; 7 means unchecked
    function automatic logic [2:0] sel_exp(input int m, input int k);
        if (k >= rdy[m] || k >= 9 || (m == 6 && k >= 6)) return 3'h7;
        if (m == 6 && k >= 3) return 3'(acs_pkg::SEL_EXT_INVERT);
        if (m == 1 || m == 5) begin
            if (k >= 6) return 3'(acs_pkg::SEL_REF_NEG);
            if (k >= 3) return 3'(acs_pkg::SEL_REF_POS);
            if (m == 1) return 3'(acs_pkg::SEL_SHORTED);
        end
        return 3'(acs_pkg::SEL_EXTERNAL);
    endfunction

    // one mode run: program, follow ticks until data ready, check results
    task automatic run(input int m, input int nc);
        int len;
        len = OSC * ((nc < 10) ? 10 : nc);
        host.ack();
        host.send(3'(m), 11'(nc));
        q.delete();
        cyc = 0;
        n = 0;
        while (data_ready_n !== 1'b0 && n < 13 && cyc <= len + 4) begin
            @(negedge sys_clk);
            cyc++;
            if (sel_exp(m, n) != 3'h7)
                chk("input_select", 72'(sel_exp(m, n)), 72'(input_select));
            if (conv_tick === 1'b1) begin
                chk("period", 72'(len), 72'(cyc));
                q.push_back(raw_result);
                n++;
                cyc = 0;
            end
        end
        chk("ticks to ready", 72'(rdy[m]), 72'(n));
        if (n == rdy[m]) begin
            if (offt[m] > 0) exp_coef.offset = q[offt[m] - 1];
            if (post[m] > 0) exp_coef.pos_gain = q[post[m] - 1];
            if (negt[m] > 0) exp_coef.neg_gain = q[negt[m] - 1];
            if (m >= 2 && m <= 4) chk("cal data", 72'(q[3]), 72'(data_out));
            else
                chk("result", 72'(corr(q[rdy[m] - 1], exp_coef)), 72'(data_out));
        end
        chk("coef", exp_coef, coef);
    endtask

    // verdict and end of run
    task automatic results();
        if (miscompares == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // watchdog
    initial begin
        #200000;
        miscompares++;
        results();
    end

    // main sequence
    initial begin
        resetn = 1'b0;
        exp_coef = {24'h000000, 24'h800000, 24'h800000};
        repeat (6) @(posedge sys_clk);
        #1 resetn = 1'b1;
        chk("reset coef", exp_coef, coef);
        chk("reset ready", 72'h1, 72'(data_ready_n));
        run(0, 10);
        chk("raw data", 72'(q[2]), 72'(data_out));
        host.ack();
        @(negedge sys_clk);
        chk("ready release", 72'h1, 72'(data_ready_n));
        // abort a self calibration midway through its first step
        host.send(3'h1, 11'd12);
        repeat (50) @(negedge sys_clk);
        run(2, 12);
        // every mode except reserved once, zero scale ahead of gain, one notch below range
        foreach (seq[i])
            run(seq[i], (i == 2) ? 4 : 10 + ({$random(seed)} % 11));
        results();
    end
endmodule // acs_sequencer_test

`default_nettype wire
